// >>> design/pcib_top.sv
// pcib_top: pci bus pin logic (master, target, parity, parking, interrupt) with write fifo
`timescale 1ns/1ps
`default_nettype none

module pcib_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign o_in_ready = cnt != (AW + 1)'(DEPTH);
   assign o_out_valid = cnt != '0;
   assign o_out_data = mem[rd_ptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb
   begin
      next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
      next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         cnt <= next_cnt;
      end
   end

   // storage carries no reset so it can map onto ram
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end
endmodule

module pcib_top (
   // clock and bus reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // bus pins, inputs and driven side
   input wire pcib_pkg::pcib_pin_in_t i_pci,
   output var pcib_pkg::pcib_pin_out_t o_pci,
   // mode controls
   input wire logic i_byte_swap_enable,
   input wire logic i_interrupt_edge_mode_select,
   // interrupt sources, mask bit high blocks a flag
   input wire logic [pcib_pkg::NIRQ-1:0] i_irq_flags,
   input wire logic [pcib_pkg::NIRQ-1:0] i_irq_mask,
   // master requests
   input wire logic i_mst_start,
   input wire pcib_pkg::pcib_mst_req_t i_mst_req,
   output logic o_mst_busy,
   output logic o_mst_done,
   output logic o_mst_err,
   // master write stream
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire pcib_pkg::pcib_word_t i_wr_word,
   // master read stream
   output logic o_rd_valid,
   output logic [pcib_pkg::AD_W-1:0] o_rd_data,
   // target side
   input wire logic [pcib_pkg::TGT_BASE_W-1:0] i_tgt_base,
   output logic o_tgt_rd,
   output logic o_tgt_wr,
   output pcib_pkg::pcib_tgt_acc_t o_tgt_acc,
   input wire logic [pcib_pkg::AD_W-1:0] i_tgt_rdata,
   // status
   output logic o_par_err
);
   pcib_pkg::pcib_core_t s, next_s;
   pcib_pkg::pcib_word_t fifo_word;
   logic fifo_valid, fifo_pop;
   logic m_addr, m_data, m_turn, mst_wr, m_last, irdy_on, frame_on, xfer_m, fin_m;
   logic t_claim, t_data, t_hold, t_turn;
   logic ad_drv, cbe_drv, addr_ph, hit_cfg, hit_mem, tgt_hit, irq_pend, par_src;

   // chain over every bus input while reset holds the pins as inputs
   function automatic logic nand_chain(input logic [pcib_pkg::PIN_IN_W-1:0] v);
      logic acc;
      acc = 1'b1;
      for (int k = 0; k < pcib_pkg::PIN_IN_W; k++)
         acc = ~(acc & v[k]);
      return acc;
   endfunction

   pcib_fifo #(
      .W(pcib_pkg::FIFO_W),
      .DEPTH(pcib_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(i_wr_valid),
      .o_in_ready(o_wr_ready),
      .i_in_data(i_wr_word),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_word)
   );

   assign m_addr = s.mst == pcib_pkg::M_ADDR;
   assign m_data = s.mst == pcib_pkg::M_DATA;
   assign m_turn = s.mst == pcib_pkg::M_TURN;
   assign t_claim = s.tgt == pcib_pkg::T_CLAIM;
   assign t_data = s.tgt == pcib_pkg::T_DATA;
   assign t_hold = s.tgt == pcib_pkg::T_HOLD;
   assign t_turn = s.tgt == pcib_pkg::T_TURN;
   assign mst_wr = s.req.cmd[0];
   // stop or abort forces the current phase to be the last one
   assign m_last = (s.left == pcib_pkg::LEN_ONE) | s.stop_seen | s.abort;
   // a write waits for fifo data; after stop or abort irdy only closes the frame
   assign irdy_on = m_data & (!mst_wr | s.have | s.abort | s.stop_seen);
   assign frame_on = m_addr | (m_data & !(m_last & irdy_on));
   assign xfer_m = irdy_on & !i_pci.trdy_n;
   assign fin_m = irdy_on & !frame_on & (!i_pci.trdy_n | !i_pci.stop_n | s.abort);
   assign fifo_pop = m_data & mst_wr & !s.have & fifo_valid & !s.stop_seen & !s.abort;
   assign ad_drv = m_addr | (m_data & mst_wr) | (t_data & !s.acc.write) | s.park;
   assign cbe_drv = m_addr | m_data | s.park;
   assign par_src = ^{s.ad, cbe_drv ? s.cbe : i_pci.cbe_n};
   // own address phases are not decoded
   assign addr_ph = !i_pci.frame_n & s.frame_q & s.irdy_q & !(m_addr | m_data | m_turn);
   assign hit_cfg = i_pci.idsel & (i_pci.cbe_n == pcib_pkg::CMD_CFG_RD
                                   | i_pci.cbe_n == pcib_pkg::CMD_CFG_WR);
   assign hit_mem = (i_pci.cbe_n == pcib_pkg::CMD_MEM_RD | i_pci.cbe_n == pcib_pkg::CMD_MEM_WR)
                    & (i_pci.ad[pcib_pkg::AD_W-1:pcib_pkg::TGT_WIN_LSB] == i_tgt_base);
   assign tgt_hit = hit_cfg | hit_mem;
   assign irq_pend = |(i_irq_flags & ~i_irq_mask);

   always_comb
   begin
      next_s = s;
      next_s.live = 1'b1;
      next_s.frame_q = i_pci.frame_n;
      next_s.irdy_q = i_pci.irdy_n;
      next_s.done = 1'b0;
      next_s.err = 1'b0;
      next_s.rd_valid = 1'b0;
      next_s.tgt_rd = 1'b0;
      next_s.tgt_wr = 1'b0;
      next_s.chk_arm = 1'b0;
      // parity trails the driven lanes by one clock
      next_s.par_out = par_src;
      next_s.par_drv = ad_drv;
      next_s.par_calc = ^{i_pci.ad, i_pci.cbe_n};
      next_s.par_err = s.chk_arm & (i_pci.par != s.par_calc);
      next_s.irq = irq_pend;
      next_s.park = !i_pci.gnt_n & i_pci.frame_n & i_pci.irdy_n & !i_mst_start
                    & s.mst == pcib_pkg::M_IDLE & s.tgt == pcib_pkg::T_IDLE;
      case (s.mst)
         pcib_pkg::M_IDLE:
         begin
            if (i_mst_start)
            begin
               next_s.req = i_mst_req;
               next_s.left = (i_mst_req.len == '0) ? pcib_pkg::LEN_ONE : i_mst_req.len;
               next_s.mst = pcib_pkg::M_REQ;
            end
         end
         pcib_pkg::M_REQ:
         begin
            if (!i_pci.gnt_n & i_pci.frame_n & i_pci.irdy_n & s.tgt == pcib_pkg::T_IDLE)
            begin
               next_s.mst = pcib_pkg::M_ADDR;
               next_s.ad = {s.req.addr[pcib_pkg::AD_W-1:2], pcib_pkg::BURST_LINEAR};
               next_s.cbe = s.req.cmd;
               next_s.have = 1'b0;
               next_s.stop_seen = 1'b0;
               next_s.dev_seen = 1'b0;
               next_s.abort = 1'b0;
               next_s.dev_tmr = '0;
            end
         end
         pcib_pkg::M_ADDR:
         begin
            next_s.mst = pcib_pkg::M_DATA;
            next_s.cbe = pcib_pkg::BE_ALL_N;
         end
         pcib_pkg::M_DATA:
         begin
            if (!i_pci.devsel_n)
               next_s.dev_seen = 1'b1;
            else if (!s.dev_seen)
            begin
               next_s.dev_tmr = s.dev_tmr + 3'h1;
               if (s.dev_tmr == pcib_pkg::DEVSEL_WAIT)
                  next_s.abort = 1'b1;
            end
            if (!i_pci.stop_n)
               next_s.stop_seen = 1'b1;
            if (fifo_pop)
            begin
               next_s.ad = pcib_pkg::swap32(i_byte_swap_enable, fifo_word.data);
               next_s.cbe = fifo_word.be_n;
               next_s.have = 1'b1;
            end
            if (xfer_m)
            begin
               next_s.left = s.left - pcib_pkg::LEN_ONE;
               next_s.have = 1'b0;
               if (!mst_wr)
               begin
                  next_s.rd_valid = 1'b1;
                  next_s.rd_data = pcib_pkg::swap32(i_byte_swap_enable, i_pci.ad);
                  next_s.chk_arm = 1'b1;
               end
            end
            if (fin_m)
            begin
               next_s.mst = pcib_pkg::M_TURN;
               next_s.done = 1'b1;
               next_s.err = s.abort | !xfer_m | (s.left != pcib_pkg::LEN_ONE);
            end
         end
         pcib_pkg::M_TURN:
            next_s.mst = pcib_pkg::M_IDLE;
         default:
            next_s.mst = pcib_pkg::M_IDLE;
      endcase
      case (s.tgt)
         pcib_pkg::T_IDLE:
         begin
            if (addr_ph)
            begin
               next_s.chk_arm = 1'b1;
               if (tgt_hit)
               begin
                  next_s.tgt = pcib_pkg::T_CLAIM;
                  next_s.acc.addr = i_pci.ad;
                  next_s.acc.write = i_pci.cbe_n[0];
                  next_s.acc.cfg = hit_cfg;
                  next_s.tgt_rd = !i_pci.cbe_n[0];
               end
            end
         end
         pcib_pkg::T_CLAIM:
         begin
            next_s.tgt = pcib_pkg::T_DATA;
            if (!s.acc.write)
               next_s.ad = i_tgt_rdata;
         end
         pcib_pkg::T_DATA:
         begin
            if (!i_pci.irdy_n)
            begin
               if (s.acc.write)
               begin
                  next_s.acc.wdata = i_pci.ad;
                  next_s.acc.be_n = i_pci.cbe_n;
                  next_s.tgt_wr = 1'b1;
                  next_s.chk_arm = 1'b1;
               end
               next_s.tgt = i_pci.frame_n ? pcib_pkg::T_TURN : pcib_pkg::T_HOLD;
            end
         end
         pcib_pkg::T_HOLD:
         begin
            if (i_pci.frame_n)
               next_s.tgt = pcib_pkg::T_TURN;
         end
         pcib_pkg::T_TURN:
            next_s.tgt = pcib_pkg::T_IDLE;
         default:
            next_s.tgt = pcib_pkg::T_IDLE;
      endcase
   end

   // single clock domain: bus and buffering share i_ref_clk
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         s <= pcib_pkg::CORE_RST;
      else
         s <= next_s;
   end

   always_comb
   begin
      o_pci.ad = s.ad;
      o_pci.ad_oe_n = !ad_drv;
      o_pci.cbe_n = s.cbe;
      o_pci.cbe_oe_n = !cbe_drv;
      o_pci.par = s.par_out;
      o_pci.par_oe_n = !s.par_drv;
      o_pci.frame_n = !frame_on;
      o_pci.irdy_n = !irdy_on;
      o_pci.mctl_oe_n = !(m_addr | m_data | m_turn);
      o_pci.devsel_n = !(t_claim | t_data | t_hold);
      // one data phase per access: stop goes with trdy to disconnect bursts
      o_pci.trdy_n = !t_data;
      o_pci.stop_n = !(t_data | t_hold);
      o_pci.tctl_oe_n = !(t_claim | t_data | t_hold | t_turn);
      o_pci.req_n = s.mst != pcib_pkg::M_REQ;
      o_pci.req_oe_n = !s.live;
      if (!i_rst_n)
      begin
         o_pci.inta = nand_chain(i_pci);
         o_pci.inta_oe_n = 1'b0;
      end
      else if (i_interrupt_edge_mode_select)
      begin
         o_pci.inta = s.irq;
         o_pci.inta_oe_n = 1'b0;
      end
      else
      begin
         o_pci.inta = 1'b0;
         o_pci.inta_oe_n = !s.irq;
      end
   end

   assign o_mst_busy = s.mst != pcib_pkg::M_IDLE;
   assign o_mst_done = s.done;
   assign o_mst_err = s.err;
   assign o_rd_valid = s.rd_valid;
   assign o_rd_data = s.rd_data;
   assign o_tgt_rd = s.tgt_rd;
   assign o_tgt_wr = s.tgt_wr;
   assign o_tgt_acc = s.acc;
   assign o_par_err = s.par_err;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_tgt_rd_claim;
      t_claim && !s.acc.write;
   endsequence
   sequence s_lvl_pend;
      !i_interrupt_edge_mode_select && irq_pend ##1 !i_interrupt_edge_mode_select;
   endsequence
   sequence s_lvl_quiet;
      !i_interrupt_edge_mode_select && !irq_pend ##1 !i_interrupt_edge_mode_select;
   endsequence

   property p_addr_phase;
      m_addr |-> (!o_pci.ad_oe_n && !o_pci.frame_n && o_pci.ad[1:0] == pcib_pkg::BURST_LINEAR
                  && o_pci.ad[31:2] == s.req.addr[31:2] && o_pci.cbe_n == s.req.cmd);
   endproperty
   a_addr_phase: assert property (p_addr_phase) else $error("bad master address phase");

   property p_frame_last;
      (m_data && o_pci.frame_n) |-> !o_pci.irdy_n;
   endproperty
   a_frame_last: assert property (p_frame_last) else $error("frame dropped without irdy");

   property p_rd_capture;
      (m_data && !mst_wr && !o_pci.irdy_n && !i_pci.trdy_n)
         |=> (o_rd_valid && s.left == $past(s.left) - pcib_pkg::LEN_ONE);
   endproperty
   a_rd_capture: assert property (p_rd_capture) else $error("read phase not taken");

   property p_par_gen;
      !o_pci.ad_oe_n |=> (!o_pci.par_oe_n && o_pci.par == $past(par_src));
   endproperty
   a_par_gen: assert property (p_par_gen) else $error("parity not driven after lanes");

   property p_par_chk;
      (s.chk_arm && i_pci.par != s.par_calc) |=> o_par_err;
   endproperty
   a_par_chk: assert property (p_par_chk) else $error("parity error missed");

   property p_claim;
      (s.tgt == pcib_pkg::T_IDLE && addr_ph && tgt_hit) |=> (!o_pci.devsel_n && !o_pci.tctl_oe_n);
   endproperty
   a_claim: assert property (p_claim) else $error("hit not claimed");

   property p_tgt_read;
      s_tgt_rd_claim |=> (!o_pci.trdy_n && !o_pci.ad_oe_n && o_pci.ad == $past(i_tgt_rdata));
   endproperty
   a_tgt_read: assert property (p_tgt_read) else $error("target read data not presented");

   property p_tgt_write;
      (t_data && s.acc.write && !i_pci.irdy_n) |=> (o_tgt_wr && o_tgt_acc.wdata == $past(i_pci.ad));
   endproperty
   a_tgt_write: assert property (p_tgt_write) else $error("target write lost");

   property p_park;
      (!i_pci.gnt_n && i_pci.frame_n && i_pci.irdy_n && !i_mst_start
       && s.mst == pcib_pkg::M_IDLE && s.tgt == pcib_pkg::T_IDLE)
         |=> (!o_pci.ad_oe_n && !o_pci.cbe_oe_n);
   endproperty
   a_park: assert property (p_park) else $error("parked bus not driven");

   property p_irq_level;
      s_lvl_pend |-> (!o_pci.inta_oe_n && !o_pci.inta);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not asserted");

   property p_irq_release;
      s_lvl_quiet |-> o_pci.inta_oe_n;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("interrupt not released");
endmodule

`default_nettype wire

// >>> design/pcib_pkg.sv
// pcib_pkg: constants and carrier types shared by the pci bus pin block
// Behaviour
// - first clock carries the 32-bit address, later clocks carry data on AD
// - little-endian lanes by default; byte swap on master write (fifo) and master read data when enabled
// - as master, drive the dword address on AD[31:2] and 00 on AD[1:0]
// - when not master, watch the lanes for an address hitting our spaces
// - drive AD for master writes and target reads; latch for the others
// - C/BE carries command in address phase, lane-wise byte enables in data phases
// - every bus signal is sampled on the rising clock edge
// - bus interface and buffering run from the bus clock only
// - drive device-select when claimed; as initiator sample it for a claim
// - master asserts FRAME to start, holds it, drops it before last phase
// - as target, sample FRAME to find each address phase
// - park: granted while idle without request, drive AD, C/BE and PAR
// - IDSEL is the chip select for configuration reads and writes
// - a data phase completes only when IRDY and TRDY are both asserted
// - as initiator, assert IRDY on valid write data or read readiness
// - as target, check IRDY for write data valid or read acceptance
// - PAR is even parity over AD and C/BE
// - as master, generate parity for address and writes, check it on reads
// - check every address parity; as target check writes, generate on reads (the code does not check the parity of its own address phases)
// - interrupt asserts while any of seventeen unmasked status flags is set
// - interrupt is active-low open drain, or active-high edge when selected
// - during bus reset pins are nand-tree inputs, interrupt shows the result
// - as master, watch STOP to detect a target disconnect
// - as target, assert TRDY when write data can be taken or read data is valid
package pcib_pkg;
   localparam int AD_W = 32;
   localparam int CBE_W = 4;
   localparam int NIRQ = 17;
   localparam int LEN_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = AD_W + CBE_W;
   localparam int TGT_WIN_LSB = 12;
   localparam int TGT_BASE_W = AD_W - TGT_WIN_LSB;
   localparam logic [2:0] DEVSEL_WAIT = 3'h5;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [1:0] BURST_LINEAR = 2'h0;
   localparam logic [3:0] BE_ALL_N = 4'h0;
   localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;

   typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pcib_mst_st_t;
   typedef enum logic [2:0] {T_IDLE, T_CLAIM, T_DATA, T_HOLD, T_TURN} pcib_tgt_st_t;

   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic [CBE_W-1:0] cbe_n;
      logic par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, gnt_n, idsel;
   } pcib_pin_in_t;
   localparam int PIN_IN_W = $bits(pcib_pin_in_t);

   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic ad_oe_n;
      logic [CBE_W-1:0] cbe_n;
      logic cbe_oe_n, par, par_oe_n;
      logic frame_n, irdy_n, mctl_oe_n;
      logic devsel_n, trdy_n, stop_n, tctl_oe_n;
      logic req_n, req_oe_n, inta, inta_oe_n;
   } pcib_pin_out_t;

   typedef struct packed {
      logic [CBE_W-1:0] cmd;
      logic [AD_W-1:0] addr;
      logic [LEN_W-1:0] len;
   } pcib_mst_req_t;

   typedef struct packed {
      logic [AD_W-1:0] data;
      logic [CBE_W-1:0] be_n;
   } pcib_word_t;

   typedef struct packed {
      logic [AD_W-1:0] addr, wdata;
      logic [CBE_W-1:0] be_n;
      logic write, cfg;
   } pcib_tgt_acc_t;

   typedef struct packed {
      pcib_mst_st_t mst;
      pcib_tgt_st_t tgt;
      pcib_mst_req_t req;
      logic [LEN_W-1:0] left;
      logic have, stop_seen, dev_seen, abort;
      logic [2:0] dev_tmr;
      logic [AD_W-1:0] ad;
      logic [CBE_W-1:0] cbe;
      logic par_out, par_drv, park, live, frame_q, irdy_q;
      logic rd_valid;
      logic [AD_W-1:0] rd_data;
      logic done, err;
      pcib_tgt_acc_t acc;
      logic tgt_rd, tgt_wr, par_calc, chk_arm, par_err, irq;
   } pcib_core_t;
   localparam pcib_core_t CORE_RST = '0;

   // byte lanes reversed; enables stay with their physical lanes
   function automatic logic [AD_W-1:0] swap32(input logic en, input logic [AD_W-1:0] d);
      return en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction
endpackage

// >>> dv/pcib_bus_model.sv
// host side bus model: arbiter, pin resolution and a claiming target
`timescale 1ns/1ps
`default_nettype none
module pcib_bus_model (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // behaviour controls
   input wire logic i_claim,
   input wire logic i_slow,
   input wire logic i_park,
   // host as initiator: one address clock, then a single data phase
   input wire logic i_ini,
   input wire logic i_idsel,
   input wire logic [3:0] i_icmd,
   input wire logic [31:0] i_iaddr,
   // pins
   input wire pcib_pkg::pcib_pin_out_t i_dev,
   output var pcib_pkg::pcib_pin_in_t o_pin,
   // captured traffic: write data, phase count and initiator read data
   output logic [31:0] o_wdata,
   output logic [7:0] o_cnt,
   output logic [31:0] o_rdata
);
   localparam logic [31:0] RDATA = 32'h1122_3344;
   localparam logic [31:0] WDATA = 32'h0F1E_2D3C;
   logic busy, dat, wr, tog, pdrv, ppar, fq, gnt_n, ia, id;
   logic [31:0] last;
   wire logic iw = id & i_icmd[0];
   wire logic drv = (dat & !wr) | ia | iw;
   // undriven lanes show the inverse of their last level, never a copy of it
   always_comb
   begin
      o_pin = '0;
      o_pin.ad = !i_dev.ad_oe_n ? i_dev.ad : ia ? i_iaddr : iw ? WDATA
                 : drv ? RDATA : ~last;
      o_pin.cbe_n = !i_dev.cbe_oe_n ? i_dev.cbe_n : ia ? i_icmd : {4{!id}};
      o_pin.idsel = ia & i_idsel;
      o_pin.par = !i_dev.par_oe_n ? i_dev.par : pdrv ? ppar : 1'b1;
      o_pin.frame_n = (i_dev.mctl_oe_n | i_dev.frame_n) & !ia;
      o_pin.irdy_n = (i_dev.mctl_oe_n | i_dev.irdy_n) & !id;
      o_pin.devsel_n = !i_dev.tctl_oe_n ? i_dev.devsel_n : !busy;
      o_pin.trdy_n = !i_dev.tctl_oe_n ? i_dev.trdy_n : !(dat & (!i_slow | tog));
      o_pin.stop_n = i_dev.tctl_oe_n | i_dev.stop_n;
      o_pin.gnt_n = gnt_n;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {busy, dat, wr, tog, pdrv, ppar, ia, id, o_cnt, o_wdata, last, o_rdata} <= '0;
         {fq, gnt_n} <= 2'b11;
      end
      else
      begin
         fq <= o_pin.frame_n;
         gnt_n <= (i_dev.req_oe_n | i_dev.req_n) & !i_park;
         last <= o_pin.ad;
         tog <= !tog;
         pdrv <= drv;
         ppar <= ^{o_pin.ad, o_pin.cbe_n};
         dat <= busy;
         ia <= i_ini & !ia & !id;
         if (ia)
            id <= 1'b1;
         if (id && !o_pin.trdy_n)
         begin
            id <= 1'b0;
            o_rdata <= o_pin.ad;
         end
         if (!o_pin.frame_n && fq && i_claim && !i_dev.mctl_oe_n)
         begin
            busy <= 1'b1;
            wr <= o_pin.cbe_n[0];
            o_cnt <= '0;
         end
         if (!o_pin.irdy_n && !o_pin.trdy_n && dat)
         begin
            o_cnt <= o_cnt + 8'h01;
            if (wr)
               o_wdata <= o_pin.ad;
            if (o_pin.frame_n)
               {busy, dat} <= 2'b00;
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the bus pin block against the host model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, swap = 0, emode = 0, start = 0, wv = 0;
   logic claim = 1, slow = 0, park = 0, d_seen, e_seen, perr_seen = 0;
   logic [16:0] flags = '0, mask = '0;
   pcib_pkg::pcib_mst_req_t req = '0;
   pcib_pkg::pcib_word_t word = '0;
   pcib_pkg::pcib_pin_in_t pin;
   pcib_pkg::pcib_pin_out_t pout;
   logic done, err, wr_rdy, rd_v, perr, busy, tw, tr, ini = 0, idsel = 0;
   logic [31:0] rd_d, rd_got, wdata, ird, iaddr = '0;
   logic [3:0] icmd = '0;
   pcib_pkg::pcib_tgt_acc_t acc, acc_got;
   logic [7:0] cnt;
   int failures = 0, checks_done = 0, cycles = 0;
   always #4 clk = !clk;
   pcib_top DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_pci(pin), .o_pci(pout),
      .i_byte_swap_enable(swap), .i_interrupt_edge_mode_select(emode),
      .i_irq_flags(flags), .i_irq_mask(mask), .i_mst_start(start), .i_mst_req(req),
      .o_mst_busy(busy), .o_mst_done(done), .o_mst_err(err), .i_wr_valid(wv),
      .o_wr_ready(wr_rdy), .i_wr_word(word), .o_rd_valid(rd_v), .o_rd_data(rd_d),
      .i_tgt_base(20'h0_0001), .o_tgt_rd(tr), .o_tgt_wr(tw), .o_tgt_acc(acc),
      .i_tgt_rdata(32'h5566_7788), .o_par_err(perr));
   pcib_bus_model host (.i_ref_clk(clk), .i_rst_n(rst_n), .i_claim(claim), .i_slow(slow),
      .i_park(park), .i_ini(ini), .i_idsel(idsel), .i_icmd(icmd), .i_iaddr(iaddr),
      .i_dev(pout), .o_pin(pin), .o_wdata(wdata), .o_cnt(cnt), .o_rdata(ird));
   always @(negedge clk)
   begin
      if (rd_v === 1'b1)
         rd_got = rd_d;
      if (perr === 1'b1)
         perr_seen = 1'b1;
      if (tw === 1'b1 || tr === 1'b1)
         acc_got = acc;
   end
   task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // a hang of any wait loop ends here as a counted mismatch
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         summarize();
      end
   end
   function automatic logic nand_chain(input pcib_pkg::pcib_pin_in_t p);
      logic acc;
      acc = 1'b1;
      for (int i = 0; i < pcib_pkg::PIN_IN_W; i++)
         acc = ~(acc & p[i]);
      return acc;
   endfunction
   task automatic push(input logic [31:0] d);
      @(posedge clk);
      wv <= 1'b1;
      word <= '{data: d, be_n: 4'h0};
      @(posedge clk);
      while (wr_rdy !== 1'b1)
         @(posedge clk);
      wv <= 1'b0;
   endtask
   task automatic mst(input logic [3:0] cmd, input logic [31:0] addr, input logic [7:0] len);
      int n;
      @(posedge clk);
      start <= 1'b1;
      req <= '{cmd: cmd, addr: addr, len: len};
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 50 && pin.frame_n !== 1'b0; n++)
         @(negedge clk);
      check("addr", pin.ad, {addr[31:2], 2'b00});
      check("busy", busy, 1'b1);
      check("cmd", pin.cbe_n, cmd);
      @(negedge clk);
      check("apar", pin.par, ^{addr[31:2], 2'b00, cmd});
      for (n = 0; n < 80 && done !== 1'b1 && err !== 1'b1; n++)
         @(negedge clk);
      d_seen = done;
      e_seen = err;
   endtask
   task automatic t_reset();
      repeat (5) @(negedge clk);
      check("nand", {pout.ad_oe_n, pout.inta_oe_n, pout.inta}, {2'b10, nand_chain(pin)});
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // full fifo drained by one burst while the target inserts wait states
   task automatic t_fill_burst();
      @(posedge clk);
      slow <= 1'b1;
      for (int i = 0; i < 8; i++)
         push(32'hA000_0000 + i);
      @(negedge clk);
      check("full", wr_rdy, 1'b0);
      mst(pcib_pkg::CMD_MEM_WR, 32'h0000_2003, 8'h08);
      check("bdone", d_seen, 1'b1);
      check("bcount", cnt, 8'h08);
      check("blast", wdata, 32'hA000_0007);
      check("empty", wr_rdy, 1'b1);
   endtask
   task automatic t_write_one();
      @(posedge clk);
      slow <= 1'b0;
      push(32'h5A5A_0F0F);
      mst(pcib_pkg::CMD_MEM_WR, 32'h0000_3004, 8'h01);
      check("wone", {d_seen, cnt, wdata}, {1'b1, 8'h01, 32'h5A5A_0F0F});
   endtask
   task automatic t_read_swap();
      @(posedge clk);
      swap <= 1'b1;
      mst(pcib_pkg::CMD_MEM_RD, 32'h0000_4008, 8'h01);
      // read parity is judged two edges after the phase
      repeat (3) @(negedge clk);
      check("rdata", rd_got, 32'h4433_2211);
      check("rperr", perr_seen, 1'b0);
   endtask
   // no target claims the read, so the master must give up
   task automatic t_abort();
      @(posedge clk);
      claim <= 1'b0;
      mst(pcib_pkg::CMD_MEM_RD, 32'h0000_5000, 8'h01);
      check("abort", e_seen, 1'b1);
      claim <= 1'b1;
   endtask
   // host as initiator: a write into the memory window, then a configuration read
   task automatic t_target();
      @(posedge clk);
      ini <= 1'b1;
      icmd <= pcib_pkg::CMD_MEM_WR;
      iaddr <= 32'h0000_1010;
      @(posedge clk);
      ini <= 1'b0;
      repeat (8) @(negedge clk);
      check("twaddr", acc_got.addr, 32'h0000_1010);
      check("twdata", {acc_got.be_n, acc_got.wdata}, {4'h0, 32'h0F1E_2D3C});
      @(posedge clk);
      ini <= 1'b1;
      idsel <= 1'b1;
      icmd <= pcib_pkg::CMD_CFG_RD;
      iaddr <= 32'h0000_0044;
      @(posedge clk);
      ini <= 1'b0;
      repeat (8) @(negedge clk);
      check("tcfg", {acc_got.cfg, acc_got.write, acc_got.addr}, {2'b10, 32'h0000_0044});
      check("trdata", ird, 32'h5566_7788);
      check("tperr", perr_seen, 1'b0);
      @(posedge clk);
      idsel <= 1'b0;
   endtask
   task automatic t_park();
      @(posedge clk);
      park <= 1'b1;
      repeat (4) @(negedge clk);
      check("park", {pout.ad_oe_n, pout.cbe_oe_n, pout.par_oe_n}, 3'b000);
      @(posedge clk);
      park <= 1'b0;
   endtask
   task automatic t_irq();
      @(posedge clk);
      flags <= 17'h1_0000;
      repeat (3) @(negedge clk);
      check("irq", {pout.inta_oe_n, pout.inta}, 2'b00);
      @(posedge clk);
      mask <= 17'h1_0000;
      repeat (3) @(negedge clk);
      check("irqmask", pout.inta_oe_n, 1'b1);
      @(posedge clk);
      emode <= 1'b1;
      mask <= '0;
      repeat (3) @(negedge clk);
      check("irqedge", {pout.inta_oe_n, pout.inta}, 2'b01);
   endtask
   initial
   begin
      t_reset();
      t_fill_burst();
      t_write_one();
      t_read_swap();
      t_abort();
      t_target();
      t_park();
      t_irq();
      summarize();
   end
endmodule
`default_nettype wire
